//--- bemon_bus_model.sv
// Slave side model of the monitored bus, answering reads after a set latency
`timescale 1ns/1ps
`default_nettype none
module bemon_bus_model (
  input  wire logic       i_ref_clk,       // Bus clock
  input  wire logic       i_rst_b,         // Async reset, active low
  input  wire logic       i_read,          // Master read
  input  wire logic       i_write,         // Master write
  input  wire logic [6:0] i_burst,         // Master burst count
  input  wire logic       i_stall,         // Slave stall request
  input  wire logic [3:0] i_lat,           // Read latency in cycles
  output var bemon_pkg::bemon_bus_t o_bus  // Bus seen by the monitor
);
  logic [7:0] cnt_r;
  logic [6:0] len_r;
  logic       rdv_r;
  // Decode of accepted read and beat window edges
  wire logic       take  = i_read & ~i_write & ~i_stall;
  wire logic [7:0] first = 8'(i_lat) - 8'h01;
  wire logic [7:0] last  = 8'(i_lat) + 8'(len_r) - 8'h01;
  // Beats back to back, first one sampled i_lat edges after accept
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 8'h00;
      len_r <= 7'h00;
      rdv_r <= 1'b0;
    end else if (take) begin
      cnt_r <= 8'h01;
      len_r <= i_burst;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= (cnt_r == last) ? 8'h00 : cnt_r + 8'h01;
      rdv_r <= (cnt_r >= first) && (cnt_r < last);
    end
  end
  // Bus bundle, master fields pass straight through
  assign o_bus = '{read: i_read, write: i_write, waitrequest: i_stall,
                   readdatavalid: rdv_r, burstcount: i_burst};
endmodule : bemon_bus_model
`default_nettype wire

//--- bemon_monitor.sv
// Bus efficiency monitor and protocol checker with status port
`timescale 1ns/1ps
`default_nettype none
module bemon_monitor (
  input  wire logic                 i_ref_clk,    // Bus clock, 25 MHz
  input  wire logic                 i_rst_b,      // Async reset, low
  input  wire bemon_pkg::bemon_bus_t i_bus,       // Monitored bus
  input  wire bemon_pkg::bemon_csr_t i_csr,       // Status port request
  output logic [31:0]               o_csr_rdata,  // Status read data
  output logic                      o_csr_rvalid  // Read data valid
);
  localparam int unsigned FW = 32 + bemon_pkg::BURST_W;

  // ========================================================
  // Saturating 32-bit add, overflow in the top bit
  function automatic logic [32:0] sat_add(input logic [31:0] a,
                                          input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[32] ? {1'b1, 32'hFFFF_FFFF} : s;
  endfunction : sat_add

  bemon_pkg::bemon_state_t state_r;
  bemon_pkg::bemon_state_t state_nxt;
  logic                    run_r;
  logic                    sat_r;
  logic [7:0]              flags_r;
  logic [31:0]             live_r [0:bemon_pkg::N_WORD-1];
  logic [31:0]             snap_r [0:bemon_pkg::N_WORD-1];
  logic [31:0]             now_r;
  logic [bemon_pkg::BURST_W-1:0] wr_left_r;
  logic [bemon_pkg::BURST_W-1:0] wr_len_r;
  logic [bemon_pkg::BURST_W-1:0] rd_left_r;
  bemon_pkg::bemon_bus_t   prev_r;
  logic [31:0]             rdata_nxt;
  logic [31:0]             inc_w [0:bemon_pkg::N_CNT-1];
  logic [32:0]             sum_w [0:bemon_pkg::N_CNT-1];
  logic [bemon_pkg::N_CNT-1:0] sat_vec;
  logic [7:0]              viol;
  logic [FW-1:0]           q_head;
  logic                    q_full;
  logic                    q_empty;

  // ========================================================
  // Bus cycle classification
  wire cmd        = i_bus.read || i_bus.write;
  wire rd_acc     = i_bus.read && !i_bus.waitrequest;
  wire wr_acc     = i_bus.write && !i_bus.waitrequest;
  wire beat       = wr_acc || i_bus.readdatavalid;
  wire in_wburst  = (wr_left_r != '0);
  wire rd_busy    = (rd_left_r != '0);
  wire pending    = !q_empty || rd_busy;
  wire first_beat = i_bus.readdatavalid && !rd_busy;
  wire active     = (state_r == bemon_pkg::ST_RUN) ||
                    ((state_r == bemon_pkg::ST_WAIT) && cmd);

  // Status port strobes
  wire ctl_wr     = i_csr.write && (i_csr.addr == bemon_pkg::OFS_CTRL);
  wire clr_stats  = ctl_wr && !i_csr.wdata[bemon_pkg::CTL_CLR_STATS];
  wire clr_flags  = ctl_wr && !i_csr.wdata[bemon_pkg::CTL_CLR_FLAGS];
  wire snap_take  = i_csr.read && (i_csr.addr == bemon_pkg::OFS_TYPE);

  // ========================================================
  // Per-counter increments
  assign inc_w[bemon_pkg::IDX_ELAPSED] = 32'h0000_0001;
  assign inc_w[bemon_pkg::IDX_BEAT]    = 32'(beat);
  assign inc_w[bemon_pkg::IDX_WRITE]   = 32'(wr_acc);
  assign inc_w[bemon_pkg::IDX_RDCMD]   = 32'(rd_acc);
  assign inc_w[bemon_pkg::IDX_RDTOT]   =
    rd_acc ? 32'(i_bus.burstcount) : 32'h0000_0000;
  assign inc_w[bemon_pkg::IDX_STALL]   =
    32'(!beat && cmd && i_bus.waitrequest);
  assign inc_w[bemon_pkg::IDX_NODATA]  = 32'(!beat && pending);
  assign inc_w[bemon_pkg::IDX_WGAP]    = 32'(!beat && !cmd);
  assign inc_w[bemon_pkg::IDX_IDLE]    =
    32'(!beat && !cmd && !in_wburst);

  // Saturating next values for every counter
  for (genvar g = 0; g < bemon_pkg::N_CNT; g++) begin : g_sum
    assign sum_w[g]   = sat_add(live_r[g], inc_w[g]);
    assign sat_vec[g] = sum_w[g][32];
  end

  // ========================================================
  // Read latency from the head time stamp
  wire [31:0] lat_w  = now_r - q_head[31:0];
  wire        lat_ok = active && first_beat && !q_empty;
  wire [63:0] tot_in = {live_r[bemon_pkg::IDX_SUM_HI],
                        live_r[bemon_pkg::IDX_SUM_LO]};
  wire [64:0] tot_w  = {1'b0, tot_in} + {33'h0, lat_w};
  wire [63:0] tot_s  = tot_w[64] ? {64{1'b1}} : tot_w[63:0];
  wire        sat_ev = active && ((|sat_vec) || (lat_ok && tot_w[64]));

  bemon_stamp_fifo #(
    .W  (FW),
    .AW (bemon_pkg::LAT_AW)
  ) u_stamp_q (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_clear   (clr_flags),
    .i_push    (rd_acc),
    .i_data    ({i_bus.burstcount, now_r}),
    .i_pop     (first_beat),
    .o_data    (q_head),
    .o_full    (q_full),
    .o_empty   (q_empty)
  );

  // ========================================================
  // Protocol checks, one flag per violation kind
  assign viol[0] = i_bus.read && i_bus.write;
  assign viol[1] = cmd && (i_bus.burstcount == '0);
  assign viol[2] = i_bus.read && in_wburst;
  assign viol[3] =
    (prev_r.read && prev_r.waitrequest && !i_bus.read) ||
    (prev_r.write && prev_r.waitrequest && !i_bus.write);
  assign viol[4] = cmd && (prev_r.read || prev_r.write) &&
                   prev_r.waitrequest &&
                   (i_bus.burstcount != prev_r.burstcount);
  assign viol[5] = i_bus.readdatavalid && !pending;
  assign viol[6] = rd_acc && q_full;
  assign viol[7] = wr_acc && in_wburst &&
                   (i_bus.burstcount != wr_len_r);

  // ========================================================
  // Gathering state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bemon_pkg::ST_STOP: begin
        if (run_r) state_nxt = bemon_pkg::ST_WAIT;
      end
      bemon_pkg::ST_WAIT: begin
        if (!run_r) state_nxt = bemon_pkg::ST_STOP;
        else if (cmd) state_nxt = bemon_pkg::ST_RUN;
      end
      bemon_pkg::ST_RUN: begin
        if (!run_r) state_nxt = bemon_pkg::ST_STOP;
      end
      default: state_nxt = bemon_pkg::ST_STOP;
    endcase
  end

  // State, run control, saturation and violation flags
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= bemon_pkg::ST_STOP;
      run_r   <= 1'b0;
      sat_r   <= 1'b0;
      flags_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (ctl_wr) run_r <= i_csr.wdata[bemon_pkg::CTL_RUN];
      sat_r   <= sat_ev || (sat_r && !clr_stats);
      flags_r <= viol | (flags_r & {8{!clr_flags}});
    end
  end

  // Burst trackers and free-running time base
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      now_r     <= 32'h0000_0000;
      wr_left_r <= '0;
      wr_len_r  <= '0;
      rd_left_r <= '0;
      prev_r    <= '0;
    end else begin
      now_r  <= now_r + 32'h0000_0001;
      prev_r <= i_bus;
      if (wr_acc && !in_wburst) begin
        wr_left_r <= i_bus.burstcount - 1'b1;
        wr_len_r  <= i_bus.burstcount;
      end else if (wr_acc) begin
        wr_left_r <= wr_left_r - 1'b1;
      end
      if (first_beat && !q_empty) begin
        rd_left_r <= q_head[FW-1:32] - 1'b1;
      end else if (i_bus.readdatavalid && rd_busy) begin
        rd_left_r <= rd_left_r - 1'b1;
      end
    end
  end

  // ========================================================
  // Live statistics, cleared by software
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < bemon_pkg::N_WORD; i++) begin
        live_r[i] <= bemon_pkg::CNT_RST;
      end
      live_r[bemon_pkg::IDX_LAT_MIN] <= bemon_pkg::LAT_MIN_RST;
    end else if (clr_stats) begin
      for (int i = 0; i < bemon_pkg::N_WORD; i++) begin
        live_r[i] <= bemon_pkg::CNT_RST;
      end
      live_r[bemon_pkg::IDX_LAT_MIN] <= bemon_pkg::LAT_MIN_RST;
    end else if (active) begin
      for (int i = 0; i < bemon_pkg::N_CNT; i++) begin
        live_r[i] <= sum_w[i][31:0];
      end
      if (lat_ok && (lat_w < live_r[bemon_pkg::IDX_LAT_MIN])) begin
        live_r[bemon_pkg::IDX_LAT_MIN] <= lat_w;
      end
      if (lat_ok && (lat_w > live_r[bemon_pkg::IDX_LAT_MAX])) begin
        live_r[bemon_pkg::IDX_LAT_MAX] <= lat_w;
      end
      if (lat_ok) begin
        live_r[bemon_pkg::IDX_SUM_LO] <= tot_s[31:0];
        live_r[bemon_pkg::IDX_SUM_HI] <= tot_s[63:32];
      end
    end
  end

  // Snapshot copy on a read of the type word
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < bemon_pkg::N_WORD; i++) begin
        snap_r[i] <= bemon_pkg::CNT_RST;
      end
    end else if (snap_take) begin
      for (int i = 0; i < bemon_pkg::N_WORD; i++) begin
        snap_r[i] <= live_r[i];
      end
    end
  end

  // ========================================================
  // Read value decode, unmapped words read zero
  wire [3:0]  st_bits = {sat_r, state_r == bemon_pkg::ST_RUN,
                         state_r == bemon_pkg::ST_WAIT,
                         state_r == bemon_pkg::ST_STOP};
  wire [31:0] ctrl_rd = (32'(run_r) << bemon_pkg::CTL_RUN) |
                        (32'(st_bits) << bemon_pkg::CTL_STATE_LSB);
  wire [31:0] wid_ad  =
    (32'(bemon_pkg::DATA_W[15:0]) << bemon_pkg::WID_HI_LSB) |
    32'(bemon_pkg::ADDR_W[15:0]);
  wire [31:0] wid_bb  =
    (32'(bemon_pkg::BURST_W[15:0]) << bemon_pkg::WID_HI_LSB) |
    32'(bemon_pkg::BE_W[15:0]);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (i_csr.addr)
      bemon_pkg::OFS_TYPE:    rdata_nxt = bemon_pkg::MON_TYPE;
      bemon_pkg::OFS_VERSION: rdata_nxt = bemon_pkg::MON_VERSION;
      bemon_pkg::OFS_CTRL:    rdata_nxt = ctrl_rd;
      bemon_pkg::OFS_WID_AD:  rdata_nxt = wid_ad;
      bemon_pkg::OFS_WID_BB:  rdata_nxt = wid_bb;
      bemon_pkg::OFS_ELAPSED: rdata_nxt = snap_r[bemon_pkg::IDX_ELAPSED];
      bemon_pkg::OFS_BEAT:    rdata_nxt = snap_r[bemon_pkg::IDX_BEAT];
      bemon_pkg::OFS_WRITE:   rdata_nxt = snap_r[bemon_pkg::IDX_WRITE];
      bemon_pkg::OFS_RDCMD:   rdata_nxt = snap_r[bemon_pkg::IDX_RDCMD];
      bemon_pkg::OFS_RDTOT:   rdata_nxt = snap_r[bemon_pkg::IDX_RDTOT];
      bemon_pkg::OFS_STALL:   rdata_nxt = snap_r[bemon_pkg::IDX_STALL];
      bemon_pkg::OFS_NODATA:  rdata_nxt = snap_r[bemon_pkg::IDX_NODATA];
      bemon_pkg::OFS_WGAP:    rdata_nxt = snap_r[bemon_pkg::IDX_WGAP];
      bemon_pkg::OFS_IDLE:    rdata_nxt = snap_r[bemon_pkg::IDX_IDLE];
      bemon_pkg::OFS_LAT_MIN: rdata_nxt = snap_r[bemon_pkg::IDX_LAT_MIN];
      bemon_pkg::OFS_LAT_MAX: rdata_nxt = snap_r[bemon_pkg::IDX_LAT_MAX];
      bemon_pkg::OFS_SUM_LO:  rdata_nxt = snap_r[bemon_pkg::IDX_SUM_LO];
      bemon_pkg::OFS_SUM_HI:  rdata_nxt = snap_r[bemon_pkg::IDX_SUM_HI];
      bemon_pkg::OFS_FLAGS:   rdata_nxt = {24'h000000, flags_r};
      default:                rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_csr_rdata  <= 32'h0000_0000;
      o_csr_rvalid <= 1'b0;
    end else begin
      o_csr_rvalid <= i_csr.read;
      if (i_csr.read) o_csr_rdata <= rdata_nxt;
    end
  end

  // ========================================================
  // Checks on the monitor's own behaviour
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  wire [31:0] beat_live = live_r[bemon_pkg::IDX_BEAT];
  wire [31:0] wr_live   = live_r[bemon_pkg::IDX_WRITE];
  wire [31:0] el_live   = live_r[bemon_pkg::IDX_ELAPSED];
  wire [31:0] beat_snap = snap_r[bemon_pkg::IDX_BEAT];
  wire [31:0] min_live  = live_r[bemon_pkg::IDX_LAT_MIN];

  snap_copy_a: assert property (
    snap_take |=> beat_snap == $past(beat_live))
    else $error("snapshot did not copy live counter");
  type_read_a: assert property (
    snap_take |=> o_csr_rvalid && o_csr_rdata == bemon_pkg::MON_TYPE)
    else $error("type word read wrong");
  clr_stats_a: assert property (
    clr_stats |=> beat_live == 32'h0000_0000 &&
      (!sat_r || $past(sat_ev)))
    else $error("clear did not zero counters");
  stop_hold_a: assert property (
    state_r == bemon_pkg::ST_STOP && !clr_stats |=>
      el_live == $past(el_live))
    else $error("counter moved while stopped");
  state_read_a: assert property (
    i_csr.read && i_csr.addr == bemon_pkg::OFS_CTRL |=>
      o_csr_rdata[bemon_pkg::CTL_STATE_LSB + 2] ==
      $past(state_r == bemon_pkg::ST_RUN))
    else $error("running bit wrong");
  width_read_a: assert property (
    i_csr.read && i_csr.addr == bemon_pkg::OFS_WID_AD |=>
      o_csr_rdata[15:0] == bemon_pkg::ADDR_W[15:0])
    else $error("address width field wrong");
  beat_count_a: assert property (
    active && beat && !clr_stats && beat_live != 32'hFFFF_FFFF |=>
      beat_live == $past(beat_live) + 32'h0000_0001)
    else $error("beat counter did not advance");
  write_count_a: assert property (
    active && !wr_acc && !clr_stats |=> wr_live == $past(wr_live))
    else $error("write counter moved without a write");
  min_track_a: assert property (
    lat_ok && !clr_stats |=> min_live <= $past(lat_w))
    else $error("minimum latency not tracked");
  flag_stick_a: assert property (
    viol[0] |=> flags_r[0] ##1 (flags_r[0] || $past(clr_flags)))
    else $error("violation flag not held");
  sat_set_a: assert property (
    active && el_live == 32'hFFFF_FFFF && !clr_stats |=>
      sat_r && el_live == 32'hFFFF_FFFF)
    else $error("counter wrapped or no saturation bit");

  snap_seen_c: cover property (snap_take ##1 o_csr_rvalid);
  run_seen_c:  cover property (state_r == bemon_pkg::ST_WAIT ##1
                               state_r == bemon_pkg::ST_RUN);
  lat_seen_c:  cover property (lat_ok);
  viol_seen_c: cover property (|viol);
endmodule : bemon_monitor
`default_nettype wire

//--- bemon_pkg.sv
// Constants and carrier types for the bus efficiency monitor
package bemon_pkg;
  // ==========================================================
  // Monitored bus shape
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned DATA_W    = 256;
  localparam int unsigned BE_W      = 32;
  localparam int unsigned BURST_W   = 7;
  // Identification words, values arbitrary
  localparam logic [31:0] MON_TYPE    = 32'h0000_0000;
  localparam logic [31:0] MON_VERSION = 32'h0000_0A01;
  // ==========================================================
  // Register word offsets
  localparam logic [7:0] OFS_TYPE    = 8'h01;
  localparam logic [7:0] OFS_VERSION = 8'h02;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_WID_AD  = 8'h10;
  localparam logic [7:0] OFS_WID_BB  = 8'h11;
  localparam logic [7:0] OFS_ELAPSED = 8'h14;
  localparam logic [7:0] OFS_BEAT    = 8'h18;
  localparam logic [7:0] OFS_WRITE   = 8'h1C;
  localparam logic [7:0] OFS_RDCMD   = 8'h20;
  localparam logic [7:0] OFS_RDTOT   = 8'h24;
  localparam logic [7:0] OFS_STALL   = 8'h28;
  localparam logic [7:0] OFS_NODATA  = 8'h2C;
  localparam logic [7:0] OFS_WGAP    = 8'h30;
  localparam logic [7:0] OFS_IDLE    = 8'h34;
  localparam logic [7:0] OFS_LAT_MIN = 8'h40;
  localparam logic [7:0] OFS_LAT_MAX = 8'h44;
  localparam logic [7:0] OFS_SUM_LO  = 8'h48;
  localparam logic [7:0] OFS_SUM_HI  = 8'h49;
  localparam logic [7:0] OFS_FLAGS   = 8'h50;
  // ==========================================================
  // Control word fields and width word half position
  localparam int unsigned CTL_CLR_STATS = 0;
  localparam int unsigned CTL_CLR_FLAGS = 8;
  localparam int unsigned CTL_RUN       = 16;
  localparam int unsigned CTL_STATE_LSB = 24;
  localparam int unsigned WID_HI_LSB    = 16;
  // Reset values
  localparam logic [31:0] CNT_RST     = 32'h0000_0000;
  localparam logic [31:0] LAT_MIN_RST = 32'hFFFF_FFFF;
  // ==========================================================
  // Statistic word indices, counters first
  localparam int unsigned N_CNT       = 9;
  localparam int unsigned N_WORD      = 13;
  localparam int unsigned IDX_ELAPSED = 0;
  localparam int unsigned IDX_BEAT    = 1;
  localparam int unsigned IDX_WRITE   = 2;
  localparam int unsigned IDX_RDCMD   = 3;
  localparam int unsigned IDX_RDTOT   = 4;
  localparam int unsigned IDX_STALL   = 5;
  localparam int unsigned IDX_NODATA  = 6;
  localparam int unsigned IDX_WGAP    = 7;
  localparam int unsigned IDX_IDLE    = 8;
  localparam int unsigned IDX_LAT_MIN = 9;
  localparam int unsigned IDX_LAT_MAX = 10;
  localparam int unsigned IDX_SUM_LO  = 11;
  localparam int unsigned IDX_SUM_HI  = 12;
  // Read time-stamp queue depth as address bits
  localparam int unsigned LAT_AW      = 4;
  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic               read;
    logic               write;
    logic               waitrequest;
    logic               readdatavalid;
    logic [BURST_W-1:0] burstcount;
  } bemon_bus_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic        read;
    logic        write;
    logic [31:0] wdata;
  } bemon_csr_t;
  typedef enum {ST_STOP, ST_WAIT, ST_RUN} bemon_state_t;
endpackage : bemon_pkg

//--- bemon_stamp_fifo.sv
// Time-stamp queue for outstanding read commands
`timescale 1ns/1ps
`default_nettype none
module bemon_stamp_fifo #(
  parameter int unsigned W  = 39,
  parameter int unsigned AW = 4
) (
  input  wire logic         i_ref_clk,  // Monitor clock
  input  wire logic         i_rst_b,    // Async reset, active low
  input  wire logic         i_clear,    // Drop all entries
  input  wire logic         i_push,     // Write one entry
  input  wire logic [W-1:0] i_data,     // Entry to write
  input  wire logic         i_pop,      // Drop head entry
  output logic      [W-1:0] o_data,     // Head entry
  output logic              o_full,     // No room left
  output logic              o_empty     // No entry held
);
  logic [W-1:0] mem_r [0:(1<<AW)-1];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  wire          do_push = i_push && !o_full;
  wire          do_pop  = i_pop && !o_empty;

  // ========================================
  // Flags and head from pointers
  assign o_empty = (wp_r == rp_r);
  assign o_full  = (wp_r[AW] != rp_r[AW]) &&
                   (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign o_data  = mem_r[rp_r[AW-1:0]];

  // Pointer update
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (i_clear) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop) rp_r <= rp_r + 1'b1;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (do_push) mem_r[wp_r[AW-1:0]] <= i_data;
  end
endmodule : bemon_stamp_fifo
`default_nettype wire

//--- test_bemon_monitor.sv
// Self-checking bench for the bus efficiency monitor
`timescale 1ns/1ps
`default_nettype none
module test_bemon_monitor;
  logic                  i_ref_clk = 1'b0;
  logic                  i_rst_b   = 1'b0;
  logic                  rd = 1'b0, wr = 1'b0, stall = 1'b0;
  logic [6:0]            burst = 7'h01;
  logic [3:0]            lat = 4'h2;
  bemon_pkg::bemon_bus_t bus;
  bemon_pkg::bemon_csr_t control_status_port = '0;
  logic [31:0]           rdata;
  logic                  rvalid;
  int                    error_cnt = 0;
  int                    compares = 0;
  int                    n, k;
  // ==========================================================
  // Design and bus partner
  bemon_monitor DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_bus(bus),
    .i_csr(control_status_port), .o_csr_rdata(rdata), .o_csr_rvalid(rvalid));
  bemon_bus_model u_bus (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_read(rd), .i_write(wr), .i_burst(burst), .i_stall(stall),
    .i_lat(lat), .o_bus(bus));
  // Clock and watchdog
  initial forever #20 i_ref_clk = ~i_ref_clk;
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] ctl_exp(input int run, input int st);
    return (32'(run) << 16) | (32'h1 << (24 + st));
  endfunction : ctl_exp
  function automatic logic [31:0] wid(input int hi, input int lo);
    return {hi[15:0], lo[15:0]};
  endfunction : wid
  // Comparison, port cycles and verdict
  task automatic chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge i_ref_clk);
    control_status_port.addr = a;
    control_status_port.read = 1'b1;
    @(negedge i_ref_clk);
    control_status_port.read = 1'b0;
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk($sformatf("word %h", a), rdata, exp);
  endtask : rd_chk
  task automatic csr_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_ref_clk);
    control_status_port.addr  = a;
    control_status_port.wdata = d;
    control_status_port.write = 1'b1;
    @(negedge i_ref_clk);
    control_status_port.write = 1'b0;
  endtask : csr_wr
  task automatic bus_cyc(input logic r, w, input int b, input logic s);
    @(negedge i_ref_clk);
    rd    = r;
    wr    = w;
    burst = 7'(b);
    stall = s;
  endtask : bus_cyc
  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(4));
    n   = 1 + $urandom % 4;
    k   = 2 + $urandom % 3;
    lat = 4'(2 + $urandom % 4);
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    rd_chk(bemon_pkg::OFS_TYPE, bemon_pkg::MON_TYPE);
    rd_chk(bemon_pkg::OFS_CTRL, ctl_exp(0, 0));
    rd_chk(bemon_pkg::OFS_WID_AD, wid(256, 32));
    rd_chk(bemon_pkg::OFS_WID_BB, wid(7, 32));
    rd_chk(bemon_pkg::OFS_LAT_MIN, 32'hFFFF_FFFF);
    rd_chk(8'h03, 32'h0000_0000);
    rd_chk(bemon_pkg::OFS_VERSION, bemon_pkg::MON_VERSION);
    csr_wr(bemon_pkg::OFS_CTRL, 32'h0001_0101);
    rd_chk(bemon_pkg::OFS_CTRL, ctl_exp(1, 1));
    // One read burst, then a stalled write burst
    bus_cyc(1, 0, n, 0);
    bus_cyc(0, 0, 1, 0);
    rd_chk(bemon_pkg::OFS_CTRL, ctl_exp(1, 2));
    repeat (lat + n + 2) @(negedge i_ref_clk);
    bus_cyc(0, 1, k, 1);
    bus_cyc(0, 1, k, 0);
    bus_cyc(0, 0, 1, 0);
    repeat (k - 1) bus_cyc(0, 1, k, 0);
    bus_cyc(0, 0, 1, 0);
    csr_wr(bemon_pkg::OFS_CTRL, 32'h0000_0101);
    rd_chk(bemon_pkg::OFS_CTRL, ctl_exp(0, 0));
    rd_chk(bemon_pkg::OFS_TYPE, 32'h0000_0000);
    rd_chk(bemon_pkg::OFS_BEAT, 32'(n + k));
    rd_chk(bemon_pkg::OFS_WRITE, 32'(k));
    rd_chk(bemon_pkg::OFS_RDCMD, 32'h0000_0001);
    rd_chk(bemon_pkg::OFS_RDTOT, 32'(n));
    rd_chk(bemon_pkg::OFS_STALL, 32'h0000_0001);
    rd_chk(bemon_pkg::OFS_NODATA, 32'(lat - 1));
    rd_chk(bemon_pkg::OFS_ELAPSED, 32'(lat + n + k + 11));
    rd_chk(bemon_pkg::OFS_WGAP, 32'(lat + 9));
    rd_chk(bemon_pkg::OFS_IDLE, 32'(lat + 8));
    rd_chk(bemon_pkg::OFS_LAT_MIN, 32'(lat));
    rd_chk(bemon_pkg::OFS_LAT_MAX, 32'(lat));
    rd_chk(bemon_pkg::OFS_SUM_LO, 32'(lat));
    rd_chk(bemon_pkg::OFS_SUM_HI, 32'h0000_0000);
    rd_chk(bemon_pkg::OFS_FLAGS, 32'h0000_0000);
    // Protocol faults while stopped, then both clears
    bus_cyc(1, 1, 1, 0);
    bus_cyc(1, 0, 0, 0);
    bus_cyc(0, 1, 2, 0);
    bus_cyc(1, 0, 2, 1);
    bus_cyc(0, 0, 1, 0);
    rd_chk(bemon_pkg::OFS_FLAGS, 32'h0000_000F);
    csr_wr(bemon_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(bemon_pkg::OFS_FLAGS, 32'h0000_0000);
    csr_wr(bemon_pkg::OFS_CTRL, 32'h0000_0100);
    rd_chk(bemon_pkg::OFS_TYPE, 32'h0000_0000);
    rd_chk(bemon_pkg::OFS_RDCMD, 32'h0000_0000);
    rd_chk(bemon_pkg::OFS_LAT_MIN, 32'hFFFF_FFFF);
    report_and_stop();
  end
endmodule : test_bemon_monitor
`default_nettype wire
